/* design/pwg_cluster_mem.sv */
// storage for the 32-bit cluster registers at c15, c3 to c6
// assumes at most one write and one read per cycle; read data registered

`timescale 1ns/1ps

module pwg_cluster_mem (
	input wire logic core_clk,
	input wire logic srst,
	pwg_mem_if.store mem
);
	import pwg_pkg::*;

	logic [CLEN-1:0] word_ff [WORDS];

	// ---------------------------------------------------------------
	// store
	// ---------------------------------------------------------------
	// flop array so every word has a known value after reset
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < WORDS; i++) begin
				word_ff[i] <= CL_RESET;
			end
		end else if (mem.wr_en) begin
			word_ff[mem.wr_idx] <= mem.wr_data;
		end
	end

	// registered read port, old data on same-word collision
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mem.rd_data <= CL_RESET;
		end else begin
			mem.rd_data <= word_ff[mem.rd_idx];
		end
	end
endmodule

/* design/pwg_ctrl.sv */
// privilege write gate: aux control registers and the gate they steer
// assumes one request per cycle from the core's system register path

`timescale 1ns/1ps

module pwg_ctrl (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_el,
	input wire logic req_secure,
	input wire logic [1:0] req_op0,
	input wire logic [2:0] req_op1,
	input wire logic [3:0] req_crn,
	input wire logic [3:0] req_crm,
	input wire logic [2:0] req_op2,
	input wire logic [63:0] req_wdata,
	input wire logic req_monitor,
	input wire pwg_pkg::pwg_group_t req_core_grp,
	output logic resp_valid_ff,
	output logic [63:0] resp_rdata_ff,
	output logic resp_trap_ff,
	output logic [1:0] resp_trap_el_ff,
	output logic [63:0] aux_control_level2_ff,
	output logic [63:0] aux_control_level3_ff
);
	import pwg_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	pwg_mem_if mem ();

	logic is_aux1;
	logic is_aux2;
	logic is_aux3;
	logic is_cluster;
	logic [IDXW-1:0] cl_idx;
	pwg_group_t grp;
	logic cl_store;
	logic cl_pair;
	logic cl_pair_set;
	logic [1:0] cl_pair_sel;
	logic en2;
	logic en3;
	logic deny;
	logic [1:0] deny_el;
	logic wr_ok;
	logic [XLEN-1:0] local_rd;
	logic from_mem;

	logic [CLEN-1:0] pair_ff [PAIRS];
	logic p_valid_ff;
	logic p_mem_ff;
	logic p_trap_ff;
	logic [1:0] p_trap_el_ff;
	logic [XLEN-1:0] p_local_ff;

	// ---------------------------------------------------------------
	// encoding decode
	// ---------------------------------------------------------------
	// aux control registers by op1 selecting the owning level
	always_comb begin
		is_aux1 = 1'b0;
		is_aux2 = 1'b0;
		is_aux3 = 1'b0;
		if (req_op0 == OP0_SYS && req_crn == CRN_AUX && req_crm == CRM_AUX
				&& req_op2 == OP2_AUX) begin
			is_aux1 = (req_op1 == OP1_AUX1);
			is_aux2 = (req_op1 == OP1_AUX2);
			is_aux3 = (req_op1 == OP1_AUX3);
		end
	end

	// cluster window c15, c3 to c6; index packs crm offset with op2
	assign is_cluster = req_op0 == OP0_SYS && req_op1 == OP1_CLUSTER
		&& req_crn == CRN_CLUSTER && req_crm >= CRM_C3 && req_crm <= CRM_C6;
	assign cl_idx = {2'(req_crm[1:0] + CRM_ADJ), req_op2};

	// group, storage kind and pair mapping of each cluster slot
	always_comb begin
		grp = req_core_grp;
		cl_store = 1'b0;
		cl_pair = 1'b0;
		cl_pair_set = 1'b0;
		cl_pair_sel = PAIR_CNTEN;
		if (is_cluster) begin
			grp = GRP_NONE;
			case (req_crm)
				CRM_C3: begin
					// op2 0..2 are read-only identification words
					case (req_op2)
						3'h3: grp = GRP_AUX;
						3'h4: grp = GRP_EXT;
						3'h5, 3'h6, 3'h7: grp = GRP_PWR;
						default: grp = GRP_NONE;
					endcase
					cl_store = (grp != GRP_NONE);
				end
				CRM_C4: begin
					case (req_op2)
						3'h0: grp = GRP_TSID;
						3'h5, 3'h6: grp = GRP_PWR;
						default: grp = GRP_SCHEME;
					endcase
					cl_store = 1'b1;
				end
				CRM_C5: begin
					grp = GRP_PMU;
					case (req_op2)
						PM_CNTEN_SET, PM_CNTEN_CLR: cl_pair_sel = PAIR_CNTEN;
						PM_OVS_SET, PM_OVS_CLR: cl_pair_sel = PAIR_OVS;
						PM_INTEN_SET, PM_INTEN_CLR: cl_pair_sel = PAIR_INTEN;
						default: cl_pair_sel = PAIR_CNTEN;
					endcase
					cl_pair = req_op2 != PM_CONTROL && req_op2 != PM_SELECT;
					cl_pair_set = req_op2 == PM_CNTEN_SET || req_op2 == PM_OVS_SET
						|| req_op2 == PM_INTEN_SET;
					cl_store = !cl_pair;
				end
				default: begin
					grp = GRP_PMU;
					cl_pair_sel = PAIR_CLAIM;
					cl_pair = req_op2 == PM_CLAIM_SET || req_op2 == PM_CLAIM_CLR;
					cl_pair_set = req_op2 == PM_CLAIM_SET;
					// slot 3 reads zero, id words are read-only
					cl_store = req_op2 == PM_EVTYPE || req_op2 == PM_EVCOUNT;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// enable selection
	// ---------------------------------------------------------------
	// level-3 lower enables are not held, so those groups pass level 3
	always_comb begin
		en2 = 1'b1;
		en3 = 1'b1;
		case (grp)
			GRP_PMU: begin
				en2 = aux_control_level2_ff[CLUSTER_PERFMON_WRITE_ENABLE];
				en3 = aux_control_level3_ff[CLUSTER_PERFMON_WRITE_ENABLE];
			end
			GRP_SCHEME: begin
				en2 = aux_control_level2_ff[SCHEME_REGS_WRITE_ENABLE];
				en3 = aux_control_level3_ff[SCHEME_REGS_WRITE_ENABLE];
			end
			GRP_TSID: begin
				en2 = aux_control_level2_ff[THREAD_SCHEME_ID_WRITE_ENABLE];
				en3 = aux_control_level3_ff[THREAD_SCHEME_ID_WRITE_ENABLE];
			end
			GRP_PWR: begin
				en2 = aux_control_level2_ff[POWER_REGS_WRITE_ENABLE];
				en3 = aux_control_level3_ff[POWER_REGS_WRITE_ENABLE];
			end
			GRP_PFG: en2 = aux_control_level2_ff[FAULT_INJECTION_WRITE_ENABLE];
			GRP_EXT: en2 = aux_control_level2_ff[EXTENDED_CONTROL_WRITE_ENABLE];
			GRP_AUX: en2 = aux_control_level2_ff[AUX_CONTROL_WRITE_ENABLE];
			default: begin
				en2 = 1'b1;
				en3 = 1'b1;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// permission and trap target
	// ---------------------------------------------------------------
	// the lowest level whose check fails takes the exception, so a
	// hypervisor sees its own denial before the monitor does
	always_comb begin
		deny = 1'b0;
		deny_el = EL1;
		if (req_monitor) begin
			if (req_el < EL2 && aux_control_level2_ff[TRAP_ACTIVITY_MONITORS]) begin
				deny = 1'b1;
				deny_el = EL2;
			end else if (req_el < EL3 && aux_control_level3_ff[TRAP_ACTIVITY_MONITORS]) begin
				deny = 1'b1;
				deny_el = EL3;
			end
		end else if (is_aux2 || is_aux3) begin
			// owner level and above only; lower levels see undefined
			if (req_el < (is_aux3 ? EL3 : EL2)) begin
				deny = 1'b1;
				deny_el = (req_el == EL0) ? EL1 : req_el;
			end
		end else if (is_aux1) begin
			deny = (req_el == EL0);
			deny_el = EL1;
		end else if (is_cluster || grp != GRP_NONE) begin
			if (req_el == EL0) begin
				deny = 1'b1;
				deny_el = EL1;
			end else if (req_write && req_el == EL1 && !req_secure && !en2) begin
				deny = 1'b1;
				deny_el = EL2;
			end else if (req_write && req_el != EL3 && !en3) begin
				deny = 1'b1;
				deny_el = EL3;
			end
		end else begin
			// unmapped encoding: undefined at the requesting level
			deny = 1'b1;
			deny_el = (req_el == EL0) ? EL1 : req_el;
		end
	end

	// monitor accesses land outside this block, so no local state may move
	assign wr_ok = req_valid && req_write && !deny && !req_monitor;

	// ---------------------------------------------------------------
	// aux control registers
	// ---------------------------------------------------------------
	// masked store keeps reserved bits at zero whatever is written
	always_ff @(posedge core_clk) begin
		if (srst) begin
			aux_control_level2_ff <= AUX_RESET;
		end else if (wr_ok && is_aux2) begin
			aux_control_level2_ff <= req_wdata & AUX2_WMASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			aux_control_level3_ff <= AUX_RESET;
		end else if (wr_ok && is_aux3) begin
			aux_control_level3_ff <= req_wdata & AUX3_WMASK;
		end
	end

	// ---------------------------------------------------------------
	// set/clear pair state
	// ---------------------------------------------------------------
	// ones act, zeros leave bits alone; a blocked write never lands
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < PAIRS; i++) begin
				pair_ff[i] <= CL_RESET;
			end
		end else if (wr_ok && is_cluster && cl_pair) begin
			if (cl_pair_set) begin
				pair_ff[cl_pair_sel] <= pair_ff[cl_pair_sel] | req_wdata[CLEN-1:0];
			end else begin
				pair_ff[cl_pair_sel] <= pair_ff[cl_pair_sel] & ~req_wdata[CLEN-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// cluster register store
	// ---------------------------------------------------------------
	// read is issued every cycle; only reads of stored slots use it
	assign mem.wr_en = wr_ok && is_cluster && cl_store;
	assign mem.wr_idx = cl_idx;
	assign mem.wr_data = req_wdata[CLEN-1:0];
	assign mem.rd_idx = cl_idx;

	pwg_cluster_mem u_store (
		.core_clk(core_clk),
		.srst(srst),
		.mem(mem)
	);

	// ---------------------------------------------------------------
	// read data from local state
	// ---------------------------------------------------------------
	always_comb begin
		local_rd = AUX_RESET;
		from_mem = 1'b0;
		if (is_aux2) begin
			local_rd = aux_control_level2_ff;
		end else if (is_aux3) begin
			local_rd = aux_control_level3_ff;
		end else if (is_aux1) begin
			local_rd = AUX_RESET;
		end else if (is_cluster && cl_pair) begin
			local_rd = {{(XLEN-CLEN){1'b0}}, pair_ff[cl_pair_sel]};
		end else if (is_cluster && cl_store) begin
			from_mem = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// pipeline stage, aligned with the store's read register
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			p_valid_ff <= 1'b0;
			p_mem_ff <= 1'b0;
			p_trap_ff <= 1'b0;
			p_trap_el_ff <= EL1;
			p_local_ff <= AUX_RESET;
		end else begin
			p_valid_ff <= req_valid;
			p_mem_ff <= from_mem && !deny;
			p_trap_ff <= req_valid && deny;
			p_trap_el_ff <= deny_el;
			p_local_ff <= deny ? AUX_RESET : local_rd;
		end
	end

	// ---------------------------------------------------------------
	// response
	// ---------------------------------------------------------------
	// trapped accesses return zero so nothing leaks to a lower level
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resp_valid_ff <= 1'b0;
			resp_rdata_ff <= AUX_RESET;
			resp_trap_ff <= 1'b0;
			resp_trap_el_ff <= EL1;
		end else begin
			resp_valid_ff <= p_valid_ff;
			resp_trap_ff <= p_trap_ff;
			resp_trap_el_ff <= p_trap_el_ff;
			if (p_mem_ff) begin
				resp_rdata_ff <= {{(XLEN-CLEN){1'b0}}, mem.rd_data};
			end else begin
				resp_rdata_ff <= p_local_ff;
			end
		end
	end
endmodule

/* design/pwg_mem_if.sv */
// carrier between the gate controller and its cluster register store
// assumes both ends sit on core_clk

`timescale 1ns/1ps

interface pwg_mem_if;
	logic wr_en;
	logic [4:0] wr_idx;
	logic [31:0] wr_data;
	logic [4:0] rd_idx;
	logic [31:0] rd_data;

	modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

/* design/pwg_pkg.sv */
// constants and types for the privilege write gate block
// assumes one core clock, synchronous active-high reset

package pwg_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int XLEN = 64;
	localparam int CLEN = 32;
	localparam int IDXW = 5;
	localparam int WORDS = 32;
	localparam int PAIRS = 4;

	// ---------------------------------------------------------------
	// exception levels
	// ---------------------------------------------------------------
	localparam logic [1:0] EL0 = 2'h0;
	localparam logic [1:0] EL1 = 2'h1;
	localparam logic [1:0] EL2 = 2'h2;
	localparam logic [1:0] EL3 = 2'h3;

	// ---------------------------------------------------------------
	// aux control field positions
	// ---------------------------------------------------------------
	localparam int TRAP_ACTIVITY_MONITORS = 30;
	localparam int CLUSTER_PERFMON_WRITE_ENABLE = 12;
	localparam int SCHEME_REGS_WRITE_ENABLE = 11;
	localparam int THREAD_SCHEME_ID_WRITE_ENABLE = 10;
	localparam int POWER_REGS_WRITE_ENABLE = 7;
	localparam int FAULT_INJECTION_WRITE_ENABLE = 5;
	localparam int EXTENDED_CONTROL_WRITE_ENABLE = 1;
	localparam int AUX_CONTROL_WRITE_ENABLE = 0;

	// writable bits, everything else is reserved and reads zero
	localparam logic [63:0] AUX2_WMASK = 64'h0000_0000_4000_1CA3;
	localparam logic [63:0] AUX3_WMASK = 64'h0000_0000_4000_1C80;
	localparam logic [63:0] AUX_RESET = 64'h0000_0000_0000_0000;
	localparam logic [31:0] CL_RESET = 32'h0000_0000;

	// ---------------------------------------------------------------
	// system register encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] OP0_SYS = 2'h3;
	localparam logic [2:0] OP1_AUX1 = 3'h0;
	localparam logic [2:0] OP1_AUX2 = 3'h4;
	localparam logic [2:0] OP1_AUX3 = 3'h6;
	localparam logic [3:0] CRN_AUX = 4'h1;
	localparam logic [3:0] CRM_AUX = 4'h0;
	localparam logic [2:0] OP2_AUX = 3'h1;
	localparam logic [2:0] OP1_CLUSTER = 3'h0;
	localparam logic [3:0] CRN_CLUSTER = 4'hF;
	localparam logic [3:0] CRM_C3 = 4'h3;
	localparam logic [3:0] CRM_C4 = 4'h4;
	localparam logic [3:0] CRM_C5 = 4'h5;
	localparam logic [3:0] CRM_C6 = 4'h6;
	localparam logic [1:0] CRM_ADJ = 2'h1;

	// c5 perfmon slots
	localparam logic [2:0] PM_CONTROL = 3'h0;
	localparam logic [2:0] PM_CNTEN_SET = 3'h1;
	localparam logic [2:0] PM_CNTEN_CLR = 3'h2;
	localparam logic [2:0] PM_OVS_SET = 3'h3;
	localparam logic [2:0] PM_OVS_CLR = 3'h4;
	localparam logic [2:0] PM_SELECT = 3'h5;
	localparam logic [2:0] PM_INTEN_SET = 3'h6;
	localparam logic [2:0] PM_INTEN_CLR = 3'h7;
	// c6 perfmon slots
	localparam logic [2:0] PM_EVTYPE = 3'h1;
	localparam logic [2:0] PM_EVCOUNT = 3'h2;
	localparam logic [2:0] PM_RAZ = 3'h3;
	localparam logic [2:0] PM_CEID0 = 3'h4;
	localparam logic [2:0] PM_CEID1 = 3'h5;
	localparam logic [2:0] PM_CLAIM_SET = 3'h6;
	localparam logic [2:0] PM_CLAIM_CLR = 3'h7;

	// set/clear pair slots in the pair state array
	localparam logic [1:0] PAIR_CNTEN = 2'h0;
	localparam logic [1:0] PAIR_OVS = 2'h1;
	localparam logic [1:0] PAIR_INTEN = 2'h2;
	localparam logic [1:0] PAIR_CLAIM = 2'h3;

	// write-gate groups of the gated registers
	typedef enum logic [2:0] {
		GRP_NONE = 3'h0,
		GRP_AUX = 3'h1,
		GRP_EXT = 3'h2,
		GRP_PWR = 3'h3,
		GRP_PFG = 3'h4,
		GRP_TSID = 3'h5,
		GRP_SCHEME = 3'h6,
		GRP_PMU = 3'h7
	} pwg_group_t;

endpackage

/* verification/pwg_ctrl_assertions.sv */
// checker for the privilege write gate, bound onto pwg_ctrl
// sees only top ports; one core clock, srst synchronous active high
`timescale 1ns/1ps

module pwg_ctrl_assertions (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_el,
	input wire logic req_secure,
	input wire logic [3:0] req_crn,
	input wire logic req_monitor,
	input wire pwg_pkg::pwg_group_t req_core_grp,
	input wire logic resp_valid_ff,
	input wire logic [63:0] resp_rdata_ff,
	input wire logic resp_trap_ff,
	input wire logic [1:0] resp_trap_el_ff,
	input wire logic [63:0] aux_control_level2_ff,
	input wire logic [63:0] aux_control_level3_ff
);
	import pwg_pkg::*;
	// ----------------------------------------
	// answer timing and gate properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// writes, and writes to core registers gated by group only
	wire wr = req_valid && req_write;
	wire cg = wr && !req_monitor && req_crn != CRN_CLUSTER && req_crn != CRN_AUX
		&& req_core_grp != GRP_NONE;
	a_answer_two_on: assert property (req_valid |-> ##2 resp_valid_ff)
		else $error("answer not two cycles after request");
	a_aux2_rsvd_zero: assert property (
		(aux_control_level2_ff & ~64'h0000_0000_4000_1CA3) == 64'h0)
		else $error("reserved level-2 bit set");
	a_aux3_rsvd_zero: assert property (
		(aux_control_level3_ff & ~64'h0000_0000_4000_1C80) == 64'h0)
		else $error("reserved level-3 bit set");
	a_mon_to_two: assert property (
		req_valid && req_monitor && req_el < EL2 && aux_control_level2_ff[30]
		|-> ##2 resp_trap_ff && resp_trap_el_ff == EL2)
		else $error("monitor access not trapped to level 2");
	a_mon_to_three: assert property (
		req_valid && req_monitor && req_el == EL2 && aux_control_level3_ff[30]
		|-> ##2 resp_trap_ff && resp_trap_el_ff == EL3)
		else $error("monitor access not trapped to level 3");
	a_trap_no_data: assert property (resp_trap_ff |-> resp_valid_ff && resp_rdata_ff == 64'h0)
		else $error("trap answer carries data");
	a_ns_power_gate: assert property (
		cg && req_core_grp == GRP_PWR && req_el == EL1 && !req_secure
		&& !aux_control_level2_ff[7] |-> ##2 resp_trap_ff && resp_trap_el_ff == EL2)
		else $error("power write from level 1 not trapped");
	a_el2_scheme_gate: assert property (
		cg && req_core_grp == GRP_SCHEME && req_el == EL2 && !aux_control_level3_ff[11]
		|-> ##2 resp_trap_ff && resp_trap_el_ff == EL3)
		else $error("scheme write from level 2 not trapped");
	a_aux3_hold: assert property (
		!(wr && req_el == EL3) |=> $stable(aux_control_level3_ff))
		else $error("level-3 register moved without level-3 write");
	a_aux2_low_hold: assert property (
		wr && req_el < EL2 |=> $stable(aux_control_level2_ff))
		else $error("level-2 register moved by low level write");
endmodule

bind pwg_ctrl pwg_ctrl_assertions i_chk (.core_clk, .srst, .req_valid, .req_write, .req_el,
	.req_secure, .req_crn, .req_monitor, .req_core_grp, .resp_valid_ff, .resp_rdata_ff,
	.resp_trap_ff, .resp_trap_el_ff, .aux_control_level2_ff, .aux_control_level3_ff);

/* verification/pwg_ctrl_tb.sv */
// self-checking bench for pwg_ctrl: random gate traffic plus corner cases
// assumes the checker is bound in; 25 MHz core clock
`timescale 1ns/1ps

`define CHK(gv, ev, msg) begin checks_done++; if ((gv) !== (ev)) begin num_errors++; \
	$display("CHECK FAILED t=%0t %s", $time, msg); end end

module pwg_ctrl_tb;
	import pwg_pkg::*;
	// ----------------------------------------
	// signals and expectation helpers
	// ----------------------------------------
	localparam logic [63:0] M2 = 64'h0000_0000_4000_1CA3;
	localparam logic [63:0] M3 = 64'h0000_0000_4000_1C80;
	logic core_clk, srst, req_valid, req_write, req_secure, req_monitor, s, m;
	logic [1:0] req_el, req_op0, el;
	logic [2:0] req_op1, req_op2, op2, t, e;
	logic [3:0] req_crn, req_crm, crn, crm;
	logic [63:0] req_wdata, resp_rdata_ff, aux_control_level2_ff, aux_control_level3_ff;
	logic [63:0] got, a2, a3, d;
	logic resp_valid_ff, resp_trap_ff;
	logic [1:0] resp_trap_el_ff;
	pwg_group_t req_core_grp, g;
	logic [31:0] rng, r;
	logic [31:0] cm [3][8];
	int num_errors, checks_done, i;

	pwg_ctrl i_dut (.core_clk, .srst, .req_valid, .req_write, .req_el, .req_secure, .req_op0,
		.req_op1, .req_crn, .req_crm, .req_op2, .req_wdata, .req_monitor, .req_core_grp,
		.resp_valid_ff, .resp_rdata_ff, .resp_trap_ff, .resp_trap_el_ff,
		.aux_control_level2_ff, .aux_control_level3_ff);

	always #20 core_clk = ~core_clk;

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// enable bit position of each gated group
	function automatic int gbit(pwg_group_t x);
		case (x)
			GRP_AUX: return 0;
			GRP_EXT: return 1;
			GRP_PFG: return 5;
			GRP_PWR: return 7;
			GRP_TSID: return 10;
			GRP_SCHEME: return 11;
			default: return 12;
		endcase
	endfunction

	// group of a cluster word at c3/c4/c5
	function automatic pwg_group_t cgrp(logic [3:0] c, logic [2:0] o);
		if (c == CRM_C5)
			return GRP_PMU;
		if (c == CRM_C3)
			return o == 3'h3 ? GRP_AUX : (o == 3'h4 ? GRP_EXT : GRP_PWR);
		if (o == 3'h0)
			return GRP_TSID;
		return (o == 3'h5 || o == 3'h6) ? GRP_PWR : GRP_SCHEME;
	endfunction

	// {trap, level} expected; zero when allowed
	function automatic logic [2:0] exp_trap(logic w, logic [1:0] l, logic sc, pwg_group_t x,
		logic mn, logic [63:0] v2, logic [63:0] v3);
		if (mn) begin
			if (l < EL2 && v2[30])
				return 3'h6;
			if (l < EL3 && v3[30])
				return 3'h7;
			return 3'h0;
		end
		if (l == EL0)
			return 3'h5;
		if (!w)
			return 3'h0;
		if (l == EL1 && !sc && !v2[gbit(x)])
			return 3'h6;
		if (l != EL3 && x inside {GRP_PWR, GRP_TSID, GRP_SCHEME, GRP_PMU} && !v3[gbit(x)])
			return 3'h7;
		return 3'h0;
	endfunction

	// one request, held for its taking edge, answer read two edges on
	task automatic acc(input logic w, input logic [1:0] l, input logic sc, input logic [3:0] n,
		input logic [3:0] c, input logic [2:0] o2, input logic [2:0] o1,
		input logic [63:0] dv, input logic mn, input pwg_group_t gp);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_el <= l;
		req_secure <= sc;
		req_crn <= n;
		req_crm <= c;
		req_op2 <= o2;
		req_op1 <= o1;
		req_wdata <= dv;
		req_monitor <= mn;
		req_core_grp <= gp;
		@(posedge core_clk);
		req_valid <= 1'b0;
		// answer stands between the first and second edge after taking
		@(posedge core_clk);
		#1;
		`CHK(resp_valid_ff, 1'b1, "answer missing")
		got = resp_rdata_ff;
		t = resp_trap_ff ? {1'b1, resp_trap_el_ff} : 3'h0;
	endtask

	task automatic aux(input logic [2:0] o1, input logic [1:0] l, input logic w,
		input logic [63:0] dv);
		acc(w, l, 1'b0, CRN_AUX, CRM_AUX, OP2_AUX, o1, dv, 1'b0, GRP_NONE);
	endtask

	task automatic cl(input logic w, input logic [3:0] c, input logic [2:0] o, input logic [63:0] dv);
		acc(w, EL3, 1'b0, CRN_CLUSTER, c, o, OP1_CLUSTER, dv, 1'b0, GRP_NONE);
	endtask

	task automatic final_report();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog: ends the run with an error if the sequence has not finished by 200000 ns
	initial begin
		#200000;
		num_errors++;
		final_report();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{core_clk, req_valid, req_write, req_secure, req_monitor} = '0;
		{req_el, req_op1, req_op2, req_crn, req_crm, req_wdata} = '0;
		srst = 1'b1;
		req_op0 = OP0_SYS;
		req_core_grp = GRP_NONE;
		{num_errors, checks_done} = '0;
		rng = 32'd2878;
		cm = '{default: '0};
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		`CHK(aux_control_level2_ff, 64'h0, "level-2 reset")
		`CHK(aux_control_level3_ff, 64'h0, "level-3 reset")
		aux(OP1_AUX1, EL1, 1'b1, '1);
		aux(OP1_AUX1, EL1, 1'b0, 64'h0);
		`CHK({t, got}, 67'h0, "level-1 not zero")
		aux(OP1_AUX2, EL1, 1'b1, '1);
		`CHK(t, 3'h5, "level-2 write from level 1")
		aux(OP1_AUX3, EL2, 1'b1, '1);
		`CHK({t, aux_control_level3_ff}, {3'h6, 64'h0}, "level-3 write from level 2")
		// random enables against random requesters
		for (i = 0; i < 60; i++) begin
			a2 = {rnd(), rnd()};
			a3 = {rnd(), rnd()};
			aux(OP1_AUX2, EL3, 1'b1, a2);
			aux(OP1_AUX3, EL3, 1'b1, a3);
			a2 &= M2;
			a3 &= M3;
			aux(OP1_AUX3, EL3, 1'b0, 64'h0);
			`CHK({got, aux_control_level2_ff}, {a3, a2}, "aux fields")
			r = rnd();
			el = r[1:0];
			s = r[2];
			m = r[3] & r[4];
			d = {rnd(), rnd()};
			crm = r[6] ? CRM_C4 : CRM_C3;
			op2 = r[9:7];
			if (!r[6] && op2 < 3'h3)
				op2 = op2 + 3'h3;
			if (r[14]) begin
				crm = CRM_C5;
				op2 = PM_SELECT;
			end
			crn = r[5] ? CRN_CLUSTER : 4'hB;
			g = r[5] ? cgrp(crm, op2) : pwg_group_t'(r[12:10] == 3'h0 ? 3'h2 : r[12:10]);
			acc(1'b1, el, s, crn, crm, op2, OP1_CLUSTER, d, m, g);
			e = exp_trap(1'b1, el, s, g, m, a2, a3);
			`CHK(t, e, "write gate")
			if (r[5] && !m) begin
				if (e == 3'h0)
					cm[crm - 4'h3][op2] = d[31:0];
				acc(1'b0, el, s, crn, crm, op2, OP1_CLUSTER, 64'h0, 1'b0, g);
				e = exp_trap(1'b0, el, s, g, 1'b0, a2, a3);
				`CHK({t, got}, {e, e != 3'h0 ? 64'h0 : {32'h0, cm[crm - 4'h3][op2]}}, "readback")
			end
		end
		// set/clear pairs share one state word; zero writes do nothing
		for (i = 0; i < 4; i++) begin
			crm = i == 3 ? CRM_C6 : CRM_C5;
			op2 = i > 1 ? 3'h6 : 3'(1 + 2 * i);
			a2 = {32'h0, rnd()};
			a3 = {32'h0, rnd()};
			cl(1'b1, crm, op2, a2);
			cl(1'b1, crm, op2 + 3'h1, a3);
			cl(1'b1, crm, op2, 64'h0);
			cl(1'b1, crm, op2 + 3'h1, 64'h0);
			cl(1'b0, crm, op2, 64'h0);
			`CHK(got, a2 & ~a3, "set view")
			cl(1'b0, crm, op2 + 3'h1, 64'h0);
			`CHK(got, a2 & ~a3, "clear view")
		end
		// plain words hold 32 bits; zero slot and id words read zero
		for (i = 0; i < 7; i++) begin
			r = rnd();
			crm = i < 2 ? CRM_C5 : CRM_C6;
			op2 = i == 0 ? 3'h0 : (i == 1 ? 3'h5 : 3'(i - 1));
			cl(1'b1, crm, op2, {rnd(), r});
			cl(1'b0, crm, op2, 64'h0);
			`CHK(got, i < 4 ? {32'h0, r} : 64'h0, "cluster word")
		end
		final_report();
	end
endmodule
